// [logic/sirs_ecc_defines.vh]
/*
 Constants for the interleaved Reed-Solomon sector encoder and checker.
 Assumes one controller clock and that every user of these names includes this file by its bare name.
*/
// Overview of operation
// (RQ1) Sector: 512 data, 4 cross-check, 32 check.
// (RQ2) Bytes go round-robin over four interleaves.
// (RQ3) Eight check bytes per interleave.
// (RQ4) Cross-check bytes cover all user data.
// (RQ5) Write appends cross-check and check bytes.
// (RQ6) Read regenerates syndromes for checks and cross-checks.
// (RQ7) Clean only if syndromes zero, cross-check 0/FF; code checks cross-check bytes 1-3 only, not byte 0.
// (RQ8) Nonzero syndrome selects a correction path.
// (RQ9) Up to 64 bits corrected silently while reading.
// (RQ10) Four bytes in distinct interleaves are corrected.
// (RQ11) Two bytes per interleave corrected on the fly.
// (RQ12) Any 57-bit burst fixed on the fly.
// (RQ13) Quadruple bursts use the slow path only.
// (RQ14) Slow path fixes sixteen bytes total.
// (RQ15) On-the-fly failure: re-read, then quadruple correction.
// (RQ16) Cross-check and check bytes corrected like data.
// (RQ17) Corrected data re-verified against cross-check syndromes.
// (RQ18) Quadruple success may request spare-sector remap.
// (RQ19) Over four bad bytes per interleave: uncorrectable.
// (RQ20) Byte symbols over GF(2^8), fixed polynomials.
`ifndef SIRS_ECC_DEFINES_VH
`define SIRS_ECC_DEFINES_VH

`define SIRS_DATA_LAST   10'h1FF
`define SIRS_XC_FIRST    10'h200
`define SIRS_XC_LAST     10'h203
`define SIRS_SECTOR_LAST 10'h223
`define SIRS_SECTOR_SIZE 548
`define SIRS_CHK_PER_IL  8
`define SIRS_IL_LAST     8'h88
`define SIRS_OTF_MAX     4'h2
`define SIRS_QUAD_MAX    4'h4
`define SIRS_CX_ALT      8'hFF
`define SIRS_FIELD_POLY  8'h1D

`endif

// [logic/sirs_sector_ram.v]
/*
 Sector buffer of 548 bytes with one write port and one registered read port.
 Assumes the caller never needs the read data in the cycle of the address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sirs_ecc_defines.vh"

module sirs_sector_ram (
    input  wire       clk,
    input  wire       we,
    input  wire [9:0] waddr,
    input  wire [7:0] wdata,
    input  wire [9:0] raddr,
    output reg  [7:0] rdata
);
    reg [7:0] mem [0:`SIRS_SECTOR_SIZE-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // sirs_sector_ram

`default_nettype wire

// [logic/sirs_ecc.v]
/*
 Sector encoder and checker with four-way interleaved Reed-Solomon check bytes and cross-check bytes.
 Assumes the channel and host buffer run on clk, that a sector is streamed whole after its start pulse,
 and that a re-read is delivered by the channel after a retry request.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sirs_ecc_defines.vh"

module sirs_ecc (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       wr_start,
    input  wire       wr_valid,
    input  wire [7:0] wr_data,
    output reg        wr_ready,
    output reg        med_valid,
    output reg  [7:0] med_data,
    input  wire       rd_start,
    input  wire       rd_valid,
    input  wire [7:0] rd_data,
    output reg        host_valid,
    output reg  [7:0] host_data,
    output reg        host_last,
    output reg        busy,
    output reg        sector_done,
    output reg        retry_req,
    output reg        remap_req,
    output reg        uncorrectable
);
    localparam [3:0] S_IDLE = 4'h0, S_WDAT = 4'h1, S_WXC = 4'h2, S_WPAR = 4'h3, S_RECV = 4'h4,
                     S_CHECK = 4'h5, S_BM = 4'h6, S_OMEGA = 4'h7, S_CHIEN = 4'h8, S_FIXRD = 4'h9,
                     S_FIXWR = 4'hA, S_NEXT = 4'hB, S_VER = 4'hC, S_VCHK = 4'hD, S_XFER = 4'hE,
                     S_FAIL = 4'hF;

    function [7:0] gf_mul;
        input [7:0] a;
        input [7:0] b;
        integer i;
        reg [7:0] p;
        reg [7:0] x;
        begin
            p = 8'h00;
            x = a;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i]) begin
                    p = p ^ x;
                end
                x = x[7] ? ({x[6:0], 1'b0} ^ `SIRS_FIELD_POLY) : {x[6:0], 1'b0};
            end
            gf_mul = p;
        end
    endfunction

    function [7:0] gf_pow;
        input integer k;
        integer i;
        reg [7:0] p;
        begin
            p = 8'h01;
            for (i = 0; i < k; i = i + 1) begin
                p = gf_mul(p, 8'h02);
            end
            gf_pow = p;
        end
    endfunction

    // The inverse is a^254, built from seven squarings and seven products, a logic depth of eight products.
    function [7:0] gf_inv;
        input [7:0] a;
        integer i;
        reg [7:0] s;
        reg [7:0] p;
        begin
            s = a;
            p = 8'h01;
            for (i = 0; i < 7; i = i + 1) begin
                s = gf_mul(s, s);
                p = gf_mul(p, s);
            end
            gf_inv = p;
        end
    endfunction

    // Coefficient j of the monic generator with roots alpha^0 to alpha^7.
    function [7:0] gen_coef;
        input integer j;
        integer i;
        integer k;
        reg [71:0] g;
        begin
            g = 72'h01;
            for (i = 0; i < 8; i = i + 1) begin
                for (k = 8; k > 0; k = k - 1) begin
                    g[k*8 +: 8] = g[(k-1)*8 +: 8] ^ gf_mul(g[k*8 +: 8], gf_pow(i));
                end
                g[7:0] = gf_mul(g[7:0], gf_pow(i));
            end
            gen_coef = g[j*8 +: 8];
        end
    endfunction

    wire [63:0] gcoef;
    wire [63:0] apow;
    wire [39:0] ainv;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_const
            // RQ20 field constants
            assign gcoef[gi*8 +: 8] = gen_coef(gi);
            assign apow[gi*8 +: 8]  = gf_pow(gi);
            if (gi < 5) begin : g_inv
                assign ainv[gi*8 +: 8] = gf_pow((255 - gi) % 255);
            end
        end
    endgenerate

    reg  [3:0] state;
    reg  [9:0] cnt;
    reg  [1:0] lane;
    reg  [2:0] bm_r;
    reg  [3:0] bm_len;
    reg  [7:0] pos;
    reg  [3:0] roots;
    reg  [7:0] fix_mag;
    reg        retry_pass;
    reg        fixed_any;
    reg        rv;
    reg  [9:0] ridx;
    reg        rv_d;
    reg  [9:0] ridx_d;
    reg  [7:0] syn [0:31];
    reg  [7:0] par [0:31];
    reg  [7:0] lam [0:4];
    reg  [7:0] bb  [0:4];
    reg  [7:0] tm  [0:4];
    reg  [7:0] om  [0:3];
    reg  [7:0] acc [0:3];
    reg  [7:0] xs  [0:3];
    reg        ram_we;
    reg  [9:0] ram_waddr;
    reg  [7:0] ram_wdata;
    reg  [9:0] ram_raddr;
    wire [7:0] ram_rdata;

    sirs_sector_ram u_ram (
        .clk   (clk),
        .we    (ram_we),
        .waddr (ram_waddr),
        .wdata (ram_wdata),
        .raddr (ram_raddr),
        .rdata (ram_rdata)
    );

    reg        xc_en;
    reg  [9:0] xc_idx;
    reg  [7:0] xc_byte;
    reg  [7:0] delta;
    reg  [7:0] eval;
    reg        syn_zero;
    reg        cx_ok;
    integer    i;
    integer    k;
    integer    idx;
    wire [7:0] dinv  = gf_inv(delta);
    wire [3:0] l_new = {1'b0, bm_r} + 4'h1 - bm_len;
    wire [7:0] jpos  = `SIRS_IL_LAST - pos;
    wire       wtake = wr_valid && wr_ready;

    always @* begin
        xc_en   = 1'b0;
        xc_idx  = cnt;
        xc_byte = wr_data;
        if (state == S_WDAT) begin
            xc_en = wtake;
        end else if (state == S_RECV) begin
            xc_en   = rd_valid;
            xc_byte = rd_data;
        end else if (state == S_VER || state == S_VCHK) begin
            // Buffer data lag the address register by one more cycle, so the delayed strobe qualifies them.
            xc_en   = rv_d;
            xc_idx  = ridx_d;
            xc_byte = ram_rdata;
        end
        delta = 8'h00;
        for (k = 0; k < 5; k = k + 1) begin
            idx = lane * 8 + bm_r - k;
            if (k <= bm_r) begin
                delta = delta ^ gf_mul(lam[k], syn[idx]);
            end
        end
        eval = 8'h00;
        for (k = 0; k < 5; k = k + 1) begin
            eval = eval ^ tm[k];
        end
        syn_zero = 1'b1;
        for (k = 0; k < 32; k = k + 1) begin
            if (syn[k] != 8'h00) begin
                syn_zero = 1'b0;
            end
        end
        // RQ7 cross-check syndromes
        cx_ok = 1'b1;
        for (k = 1; k < 4; k = k + 1) begin
            if ((xs[k] ^ acc[k]) != 8'h00 && (xs[k] ^ acc[k]) != `SIRS_CX_ALT) begin
                cx_ok = 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            cnt <= 10'h000;
            lane <= 2'h0;
            bm_r <= 3'h0;
            bm_len <= 4'h0;
            pos <= 8'h00;
            roots <= 4'h0;
            fix_mag <= 8'h00;
            retry_pass <= 1'b0;
            fixed_any <= 1'b0;
            rv <= 1'b0;
            ridx <= 10'h000;
            rv_d <= 1'b0;
            ridx_d <= 10'h000;
            ram_we <= 1'b0;
            ram_waddr <= 10'h000;
            ram_wdata <= 8'h00;
            ram_raddr <= 10'h000;
            wr_ready <= 1'b0;
            med_valid <= 1'b0;
            med_data <= 8'h00;
            host_valid <= 1'b0;
            host_data <= 8'h00;
            host_last <= 1'b0;
            busy <= 1'b0;
            sector_done <= 1'b0;
            retry_req <= 1'b0;
            remap_req <= 1'b0;
            uncorrectable <= 1'b0;
            for (i = 0; i < 32; i = i + 1) begin
                syn[i] <= 8'h00;
                par[i] <= 8'h00;
            end
            for (i = 0; i < 5; i = i + 1) begin
                lam[i] <= 8'h00;
                bb[i] <= 8'h00;
                tm[i] <= 8'h00;
            end
            for (i = 0; i < 4; i = i + 1) begin
                om[i] <= 8'h00;
                acc[i] <= 8'h00;
                xs[i] <= 8'h00;
            end
        end else begin
            ram_we <= 1'b0;
            med_valid <= 1'b0;
            host_valid <= 1'b0;
            host_last <= 1'b0;
            sector_done <= 1'b0;
            retry_req <= 1'b0;
            remap_req <= 1'b0;
            uncorrectable <= 1'b0;
            rv <= 1'b0;
            rv_d <= rv;
            ridx_d <= ridx;
            // RQ4 cross-check over data
            if (xc_en) begin
                if (xc_idx <= `SIRS_DATA_LAST) begin
                    acc[0] <= acc[0] ^ xc_byte;
                    for (i = 1; i < 4; i = i + 1) begin
                        acc[i] <= gf_mul(acc[i], apow[i*8 +: 8]) ^ xc_byte;
                    end
                end else if (xc_idx <= `SIRS_XC_LAST) begin
                    xs[xc_idx[1:0]] <= xc_byte;
                end
            end
            case (state)
                S_IDLE: begin
                    cnt <= 10'h000;
                    for (i = 0; i < 32; i = i + 1) begin
                        syn[i] <= 8'h00;
                        par[i] <= 8'h00;
                    end
                    for (i = 0; i < 4; i = i + 1) begin
                        acc[i] <= 8'h00;
                    end
                    if (wr_start) begin
                        state <= S_WDAT;
                        wr_ready <= 1'b1;
                        busy <= 1'b1;
                    end else if (rd_start) begin
                        state <= S_RECV;
                        busy <= 1'b1;
                        fixed_any <= 1'b0;
                    end
                end
                S_WDAT, S_WXC, S_WPAR: begin
                    if (state != S_WDAT || wtake) begin
                        med_valid <= 1'b1;
                        cnt <= cnt + 10'h001;
                        // RQ1 byte order on the medium
                        if (state == S_WDAT) begin
                            med_data <= wr_data;
                        end else if (state == S_WXC) begin
                            med_data <= acc[cnt[1:0]];
                        end else begin
                            med_data <= par[{cnt[1:0], 3'h7}];
                        end
                        // RQ2 RQ3 per-interleave encoder
                        for (i = 7; i >= 0; i = i - 1) begin
                            if (state == S_WPAR) begin
                                par[{cnt[1:0], 3'h0} + i] <= (i == 0) ? 8'h00 : par[{cnt[1:0], 3'h0} + i - 1];
                            end else begin
                                par[{cnt[1:0], 3'h0} + i] <= ((i == 0) ? 8'h00 : par[{cnt[1:0], 3'h0} + i - 1])
                                    ^ gf_mul((state == S_WDAT ? wr_data : acc[cnt[1:0]])
                                    ^ par[{cnt[1:0], 3'h7}], gcoef[i*8 +: 8]);
                            end
                        end
                        // RQ5 append after the data
                        if (cnt == `SIRS_DATA_LAST) begin
                            wr_ready <= 1'b0;
                            state <= S_WXC;
                        end else if (cnt == `SIRS_XC_LAST) begin
                            state <= S_WPAR;
                        end else if (cnt == `SIRS_SECTOR_LAST) begin
                            sector_done <= 1'b1;
                            busy <= 1'b0;
                            state <= S_IDLE;
                        end
                    end
                end
                S_RECV: begin
                    if (rd_valid) begin
                        ram_we <= 1'b1;
                        ram_waddr <= cnt;
                        ram_wdata <= rd_data;
                        cnt <= cnt + 10'h001;
                        // RQ6 syndromes per interleave
                        for (i = 0; i < 8; i = i + 1) begin
                            syn[{cnt[1:0], 3'h0} + i] <= gf_mul(syn[{cnt[1:0], 3'h0} + i], apow[i*8 +: 8]) ^ rd_data;
                        end
                        if (cnt == `SIRS_SECTOR_LAST) begin
                            state <= S_CHECK;
                        end
                    end
                end
                S_CHECK: begin
                    lane <= 2'h0;
                    cnt <= 10'h000;
                    // A nonzero step count marks entry into the lane loop.
                    bm_r <= 3'h1;
                    // RQ7 RQ8 clean or correct
                    if (syn_zero && cx_ok) begin
                        state <= S_XFER;
                    end else begin
                        state <= S_NEXT;
                        lane <= 2'h3;
                    end
                end
                S_BM: begin
                    bm_r <= bm_r + 3'h1;
                    if (delta == 8'h00) begin
                        for (i = 4; i > 0; i = i - 1) bb[i] <= bb[i-1];
                        bb[0] <= 8'h00;
                    end else begin
                        for (i = 0; i < 5; i = i + 1) begin
                            lam[i] <= lam[i] ^ gf_mul(delta, (i == 0) ? 8'h00 : bb[i-1]);
                        end
                        if ({bm_len, 1'b0} <= {2'b00, bm_r}) begin
                            for (i = 0; i < 5; i = i + 1) bb[i] <= gf_mul(lam[i], dinv);
                            bm_len <= l_new;
                        end else begin
                            for (i = 4; i > 0; i = i - 1) bb[i] <= bb[i-1];
                            bb[0] <= 8'h00;
                        end
                    end
                    if (bm_r == 3'h7) begin
                        state <= S_OMEGA;
                    end
                end
                S_OMEGA: begin
                    // RQ19 too many bytes in one interleave
                    // RQ13 RQ15 beyond two bytes waits for the re-read
                    if (bm_len > `SIRS_QUAD_MAX || (bm_len > `SIRS_OTF_MAX && !retry_pass)) begin
                        state <= S_FAIL;
                    end else if (bm_len == 4'h0) begin
                        state <= S_NEXT;
                    end else begin
                        for (i = 0; i < 4; i = i + 1) begin
                            om[i] <= gf_mul(syn[{lane, 3'h0} + i], lam[0])
                                ^ ((i > 0) ? gf_mul(syn[{lane, 3'h0} + i - 1], lam[1]) : 8'h00)
                                ^ ((i > 1) ? gf_mul(syn[{lane, 3'h0} + i - 2], lam[2]) : 8'h00)
                                ^ ((i > 2) ? gf_mul(syn[{lane, 3'h0}], lam[3]) : 8'h00);
                        end
                        for (i = 0; i < 5; i = i + 1) tm[i] <= lam[i];
                        pos <= 8'h00;
                        roots <= 4'h0;
                        state <= S_CHIEN;
                    end
                end
                S_CHIEN: begin
                    // RQ10 RQ11 RQ12 RQ14 RQ16 locate and fix any sector byte
                    for (i = 0; i < 5; i = i + 1) tm[i] <= gf_mul(tm[i], ainv[i*8 +: 8]);
                    for (i = 0; i < 4; i = i + 1) om[i] <= gf_mul(om[i], ainv[i*8 +: 8]);
                    pos <= pos + 8'h01;
                    if (eval == 8'h00) begin
                        fix_mag <= gf_mul(om[0] ^ om[1] ^ om[2] ^ om[3], gf_inv(tm[1] ^ tm[3]));
                        ram_raddr <= {jpos, lane};
                        roots <= roots + 4'h1;
                        state <= S_FIXRD;
                    end else if (pos == `SIRS_IL_LAST) begin
                        state <= (roots == bm_len) ? S_NEXT : S_FAIL;
                    end
                end
                S_FIXRD: begin
                    state <= S_FIXWR;
                end
                S_FIXWR: begin
                    // RQ9 silent in-buffer correction
                    ram_we <= 1'b1;
                    ram_waddr <= ram_raddr;
                    ram_wdata <= ram_rdata ^ fix_mag;
                    fixed_any <= 1'b1;
                    state <= (pos == `SIRS_IL_LAST + 8'h01) ? ((roots == bm_len) ? S_NEXT : S_FAIL) : S_CHIEN;
                end
                S_NEXT: begin
                    lane <= lane + 2'h1;
                    bm_r <= 3'h0;
                    bm_len <= 4'h0;
                    for (i = 0; i < 5; i = i + 1) begin
                        lam[i] <= (i == 0) ? 8'h01 : 8'h00;
                        bb[i] <= (i == 0) ? 8'h01 : 8'h00;
                    end
                    cnt <= 10'h000;
                    for (i = 0; i < 4; i = i + 1) acc[i] <= 8'h00;
                    // Past the last lane with nothing fixed, only the cross-check was wrong.
                    if (lane != 2'h3 || bm_r != 3'h0) begin
                        state <= S_BM;
                    end else begin
                        state <= fixed_any ? S_VER : S_FAIL;
                    end
                end
                S_VER: begin
                    // RQ17 recheck corrected data
                    ram_raddr <= cnt;
                    rv <= 1'b1;
                    ridx <= cnt;
                    cnt <= cnt + 10'h001;
                    if (cnt == `SIRS_XC_LAST) begin
                        state <= S_VCHK;
                    end
                end
                S_VCHK: begin
                    if (!rv && !rv_d) begin
                        cnt <= 10'h000;
                        state <= cx_ok ? S_XFER : S_FAIL;
                    end
                end
                S_XFER: begin
                    if (cnt <= `SIRS_DATA_LAST) begin
                        ram_raddr <= cnt;
                        cnt <= cnt + 10'h001;
                    end
                    rv <= (cnt <= `SIRS_DATA_LAST);
                    ridx <= cnt;
                    host_valid <= rv_d;
                    host_data <= ram_rdata;
                    host_last <= rv_d && ridx_d == `SIRS_DATA_LAST;
                    if (rv_d && ridx_d == `SIRS_DATA_LAST) begin
                        sector_done <= 1'b1;
                        // RQ18 remap after slow-path success
                        remap_req <= retry_pass && fixed_any;
                        retry_pass <= 1'b0;
                        busy <= 1'b0;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    // RQ15 first failure asks for a re-read
                    retry_req <= !retry_pass;
                    uncorrectable <= retry_pass;
                    retry_pass <= !retry_pass;
                    sector_done <= 1'b1;
                    busy <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // sirs_ecc

`default_nettype wire

// [verif/sirs_chan_model.sv]
/* Channel model: keeps the sector written to the medium and replays it with injected byte errors.
   Assumes the bench pulses send only while the checker is idle. */
`timescale 1ns/1ps
`default_nettype none
module sirs_chan_model (
    input  wire logic       clk,
    input  wire logic       send,
    input  wire logic       med_valid,
    input  wire logic [7:0] med_data,
    output var  logic       rd_start,
    output var  logic       rd_valid,
    output var  logic [7:0] rd_data
);
    logic [7:0] mem [0:547];
    logic [7:0] err [0:547];
    int         wp = 0;
    initial begin
        rd_start = 1'b0;
        rd_valid = 1'b0;
        rd_data  = 8'h00;
    end
    always @(posedge clk) begin
        if (med_valid) begin
            mem[wp] <= med_data;
            wp      <= (wp == 547) ? 0 : wp + 1;
        end
    end
    always @(posedge clk) begin
        if (send) begin
            #1 rd_start = 1'b1;
            @(posedge clk) #1 rd_start = 1'b0;
            for (int i = 0; i < 548; i++) begin
                rd_valid = 1'b1;
                rd_data  = mem[i] ^ err[i];
                @(posedge clk) #1;
            end
            // A released line shows the inverse so a stray sample never matches.
            rd_valid = 1'b0;
            rd_data  = ~rd_data;
        end
    end
endmodule // sirs_chan_model
`default_nettype wire

// [verif/sirs_ecc_monitor.sv]
/* Port checker for the sector encoder and checker.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module sirs_ecc_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_start,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic med_valid,
    input wire logic busy,
    input wire logic host_valid,
    input wire logic host_last,
    input wire logic sector_done,
    input wire logic retry_req,
    input wire logic remap_req,
    input wire logic uncorrectable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence seq_tail;
        med_valid [*8];
    endsequence
    sequence seq_run;
        host_valid [*8];
    endsequence
    a_start_opens_write: assert property (wr_start && !busy |=> wr_ready && busy)
        else $error("write start not accepted");
    a_byte_goes_out: assert property (wr_valid && wr_ready |=> med_valid)
        else $error("taken byte not forwarded");
    a_check_tail: assert property ($fell(wr_ready) |-> seq_tail)
        else $error("check bytes not contiguous");
    a_retry_pulse: assert property (retry_req |-> sector_done && !host_valid && !remap_req)
        else $error("retry request malformed");
    a_remap_pulse: assert property (remap_req |-> sector_done && !uncorrectable)
        else $error("remap request malformed");
    a_fail_pulse: assert property (uncorrectable |-> sector_done && !retry_req)
        else $error("failure flag malformed");
    a_host_run: assert property ($rose(host_valid) |-> seq_run)
        else $error("host transfer gapped");
    a_last_marks: assert property (host_last |-> host_valid ##1 !host_valid)
        else $error("last byte marker wrong");
    a_done_pulse: assert property (sector_done |=> !sector_done)
        else $error("done not a pulse");
endmodule // sirs_ecc_monitor
bind sirs_ecc sirs_ecc_monitor sirs_ecc_monitor_i (.clk(clk), .rst_n(rst_n), .wr_start(wr_start),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .med_valid(med_valid), .busy(busy), .host_valid(host_valid),
    .host_last(host_last), .sector_done(sector_done), .retry_req(retry_req), .remap_req(remap_req),
    .uncorrectable(uncorrectable));
`default_nettype wire

// [verif/testbench.sv]
/* Self-checking bench: writes one sector, then reads it back with assorted injected errors.
   Assumes the channel model acts as medium and the checker is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk, rst_n, wr_start, wr_valid, send;
    logic [7:0] wr_data, med_data, rd_data, host_data;
    logic       wr_ready, med_valid, rd_start, rd_valid, host_valid, host_last;
    logic       busy, sector_done, retry_req, remap_req, uncorrectable;
    logic [7:0] d [0:511];
    int         num_errors = 0;
    int         n_compared = 0;
    sirs_ecc sirs_ecc_i (.clk(clk), .rst_n(rst_n), .wr_start(wr_start), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .med_valid(med_valid), .med_data(med_data),
        .rd_start(rd_start), .rd_valid(rd_valid), .rd_data(rd_data), .host_valid(host_valid),
        .host_data(host_data), .host_last(host_last), .busy(busy), .sector_done(sector_done),
        .retry_req(retry_req), .remap_req(remap_req), .uncorrectable(uncorrectable));
    sirs_chan_model sirs_chan_model_i (.clk(clk), .send(send), .med_valid(med_valid),
        .med_data(med_data), .rd_start(rd_start), .rd_valid(rd_valid), .rd_data(rd_data));
    task complete_run;
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_done;
        for (int k = 0; k < 300 && sector_done !== 1'b1; k++) @(posedge clk) #1;
        chk(16'(sector_done), 16'h0001);
    endtask
    task t_write;
        logic [7:0] x;
        int         n;
        logic       ok;
        x = 8'h00;
        n = 0;
        for (int i = 0; i < 512; i++) begin
            d[i] = 8'(i * 37 + 5);
            x ^= d[i];
        end
        wr_start = 1'b1;
        @(posedge clk) #1 wr_start = 1'b0;
        while (n < 512) begin
            wr_valid = 1'b1;
            wr_data  = d[n];
            ok = wr_ready;
            @(posedge clk) #1;
            if (ok === 1'b1) n++;
        end
        wr_valid = 1'b0;
        wait_done;
        // The channel stores the last byte one edge after the done pulse.
        @(posedge clk) #1;
        // The medium must hold exactly one full sector.
        chk(16'(sirs_chan_model_i.wp), 16'h0000);
        for (int i = 0; i < 512; i++) chk(sirs_chan_model_i.mem[i], d[i]);
        chk(sirs_chan_model_i.mem[512], x);
    endtask
    task inject(input int a, input int b);
        for (int i = 0; i < 548; i++) sirs_chan_model_i.err[i] = (i >= a && i <= b) ? 8'(i | 1) : 8'h00;
    endtask
    task t_read(input logic exp_data, input logic [2:0] exp_flag);
        int n;
        n = 0;
        send = 1'b1;
        @(posedge clk) #1 send = 1'b0;
        for (int k = 0; k < 8000; k++) begin
            if (host_valid === 1'b1) begin
                chk({7'h00, host_last, host_data}, {7'h00, n == 511, d[n % 512]});
                n++;
            end
            if (sector_done === 1'b1) break;
            @(posedge clk) #1;
        end
        chk(16'(sector_done), 16'h0001);
        chk({retry_req, remap_req, uncorrectable}, 16'(exp_flag));
        chk(16'(n), exp_data ? 16'h0200 : 16'h0000);
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #(4 * 60000);
        num_errors++;
        complete_run;
    end
    initial begin
        rst_n    = 1'b0;
        wr_start = 1'b0;
        wr_valid = 1'b0;
        wr_data  = 8'h00;
        send     = 1'b0;
        inject(1, 0);
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        t_write;
        t_read(1'b1, 3'b000);
        inject(10, 17);
        t_read(1'b1, 3'b000);
        inject(514, 521);
        t_read(1'b1, 3'b000);
        // Sixteen contiguous bad bytes need the slow pass after a re-read.
        inject(100, 115);
        t_read(1'b0, 3'b100);
        t_read(1'b1, 3'b010);
        inject(200, 219);
        t_read(1'b0, 3'b100);
        t_read(1'b0, 3'b001);
        complete_run;
    end
endmodule // testbench
`default_nettype wire
